// ---- hmp_pkg.sv ----
// shared constants for the host bus mailbox port
package hmp_pkg;
  // =====================================================
  // mailbox geometry
  localparam int MBX_BYTES  = 32;
  localparam int HALF_BYTES = 16;
  // =====================================================
  // address map, 7-bit register address
  localparam logic [1:0] RGN_INBOX  = 2'h0;
  localparam logic [1:0] RGN_OUTBOX = 2'h1;
  localparam logic [1:0] RGN_CTRL   = 2'h2;
  localparam logic [4:0] OFS_IN_CMD   = 5'h00;
  localparam logic [4:0] OFS_OUT_CMD  = 5'h01;
  localparam logic [4:0] OFS_OUT_BUSY = 5'h02;
  localparam logic [4:0] OFS_IN_BUSY  = 5'h03;
  localparam logic [4:0] OFS_CONFIG   = 5'h04;
  // =====================================================
  // host_config_register fields and reset value
  localparam int CFG_DMA_BIT   = 0;
  localparam int CFG_INTERRUPT_MASK_BIT_BIT = 1;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  // =====================================================
  // host strobe timing in CLK cycles
  localparam logic [3:0] ALE_CYC    = 4'h2;
  localparam logic [3:0] STROBE_CYC = 4'h4;
  localparam logic [3:0] GAP_CYC    = 4'h2;
endpackage

// ---- hmp_bus_if.sv ----
// pins between the external processor and the mailbox port
`timescale 1ns/1ps
`default_nettype none
interface hmp_bus_if;
  logic       mode;        // strap: 0 two-strobe style, 1 alternative style
  logic       ale;         // held at 1 for separate address and data
  logic       cs_n;
  logic       rd_n;        // read strobe, or data strobe in alternative style
  logic       wr_n;        // write strobe, or read/not-write in alternative style
  logic       interrupt_acknowledge_strobe_n;      // interrupt_acknowledge_strobe
  logic       int_n;
  logic [6:0] addr;        // bit 4 is not wired; shared_ack_addr4_pin carries it
  logic       shared_ack_addr4_pin;
  logic [7:0] host_d;
  logic       host_oe_n;
  logic [7:0] dev_d;
  logic       dev_oe_n;
  logic [7:0] d;
  // =====================================================
  // resolved data wire, pulled high when nobody drives
  assign d = !dev_oe_n ? dev_d : (!host_oe_n ? host_d : 8'hff);
  modport dev  (input mode, ale, cs_n, rd_n, wr_n, interrupt_acknowledge_strobe_n, addr, shared_ack_addr4_pin, d,
                output int_n, dev_d, dev_oe_n);
  modport host (input int_n, d,
                output mode, ale, cs_n, rd_n, wr_n, interrupt_acknowledge_strobe_n, addr, shared_ack_addr4_pin,
                host_d, host_oe_n);
endinterface
`default_nettype wire

// ---- hmp_device.sv ----
// device end: mailbox port facing the external processor and DMA controller
// What this block does
// R01: strap pin picks two-strobe or alternative style
// R02: address strobe stuck at one means separate buses
// R03: address pins wired to low address/data lines
// R04: alternative style uses separate buses only
// R05: only seven low address lines are decoded
// R06: DMA mode: pin is acknowledge, address bit4 zero
// R07: DMA mailbox reached only by acknowledge plus strobe
// R08: DMA mode: processor reaches general mailbox only
// R09: one configuration bit selects DMA or non-DMA
// R10: reset starts non-DMA with double-sized mailbox
// R11: each direction: 32 data bytes, one command
// R12: non-DMA: shared pin is address bit 4
// R13: single interrupt from outbox command register
// R14: clearing outbox busy drops the interrupt
// R15: cleared mask bit suppresses the interrupt
// R16: vector is outbox command register contents
// R17: vector on first or second acknowledge pulse
// R18: two-strobe first vector from external controller
// R19: multiplexed bus: line 4 goes to data bit 4
// R20: interrupt follows busy gated by mask
`timescale 1ns/1ps
`default_nettype none
module hmp_device
  import hmp_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  hmp_bus_if.dev          BUS,
  input  wire logic       DSP_OUT_WE,
  input  wire logic [4:0] DSP_OUT_IDX,
  input  wire logic [7:0] DSP_OUT_DATA,
  input  wire logic       DSP_CMD_WE,
  input  wire logic [7:0] DSP_CMD_DATA,
  input  wire logic [4:0] DSP_IN_IDX,
  output logic      [7:0] DSP_IN_DATA,
  output logic      [7:0] DSP_IN_CMD,
  output logic            IN_BUSY,
  input  wire logic       DSP_IN_DONE,
  output logic            OUT_BUSY,
  output logic            DMA_MODE,
  output logic            MUX_MODE,
  output logic            ALT_STYLE
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_READ  = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_VECT  = 5'b01000,
    ST_SKIP  = 5'b10000
  } hmp_state_t;

  // =====================================================
  // address decode, shared by the read and write paths
  function automatic logic [1:0] region(input logic [6:0] a);
    region = a[6:5];
  endfunction

  logic [7:0] inbox  [MBX_BYTES];
  logic [7:0] outbox [MBX_BYTES];
  logic [7:0] in_cmd, out_cmd, cfg, rdata, wdata, next_rdata, next_wdata;
  logic [7:0] next_in_cmd, next_out_cmd, next_cfg;
  logic       in_busy, out_busy, next_in_busy, next_out_busy;
  logic       mux_mode, next_mux_mode, interrupt_acknowledge_strobe_seen, next_interrupt_acknowledge_strobe_seen;
  logic       dma_acc, next_dma_acc;
  logic [6:0] lat_addr, next_lat_addr, acc_addr, next_acc_addr;
  logic [3:0] dma_rptr, dma_wptr, next_dma_rptr, next_dma_wptr;
  logic       prev_interrupt_acknowledge_strobe_n, next_prev_interrupt_acknowledge_strobe_n;
  hmp_state_t state, next_state;
  logic       in_we;
  logic [4:0] in_widx;
  logic       dma, alt, ds, rd_req, wr_req, strobe_on, dma_acknowledge_input, interrupt_acknowledge_strobe_start;
  logic [6:0] eff_addr;

  // =====================================================
  // pin decoding
  always_comb begin
    dma  = cfg[CFG_DMA_BIT];                                   // R09
    alt  = BUS.mode;                                            // R01
    dma_acknowledge_input = dma && !BUS.shared_ack_addr4_pin;                    // R06
    if (alt) begin
      // alternative style: data strobe plus read/not-write level
      ds     = !BUS.rd_n && (!BUS.cs_n || dma_acknowledge_input);
      rd_req = ds && BUS.wr_n;
      wr_req = ds && !BUS.wr_n;
    end else begin
      ds     = 1'b0;
      rd_req = !BUS.rd_n && (!BUS.cs_n || dma_acknowledge_input);
      wr_req = !BUS.wr_n && (!BUS.cs_n || dma_acknowledge_input);
    end
    strobe_on  = rd_req || wr_req;
    interrupt_acknowledge_strobe_start = prev_interrupt_acknowledge_strobe_n && !BUS.interrupt_acknowledge_strobe_n;
    // in multiplexed use the address is the one caught while the address strobe is high
    eff_addr    = mux_mode ? lat_addr : BUS.addr;               // R02 R03
    eff_addr[4] = dma ? 1'b0 : BUS.shared_ack_addr4_pin;        // R05 R06 R12
  end

  // =====================================================
  // bus sequencing and register state
  always_comb begin
    next_state       = state;
    next_rdata       = rdata;
    next_wdata       = wdata;
    next_cfg         = cfg;
    next_in_cmd      = in_cmd;
    next_out_cmd     = out_cmd;
    next_in_busy     = in_busy;
    next_out_busy    = out_busy;
    next_interrupt_acknowledge_strobe_seen   = interrupt_acknowledge_strobe_seen;
    next_dma_acc     = dma_acc;
    next_acc_addr    = acc_addr;
    next_dma_rptr    = dma_rptr;
    next_dma_wptr    = dma_wptr;
    next_prev_interrupt_acknowledge_strobe_n = BUS.interrupt_acknowledge_strobe_n;
    // any low on the address strobe means multiplexed use from then on
    next_mux_mode    = mux_mode || !BUS.ale;                    // R02
    next_lat_addr    = BUS.ale ? BUS.addr : lat_addr;
    in_we            = 1'b0;
    in_widx          = 5'h00;
    case (state)
      ST_IDLE: begin
        if (interrupt_acknowledge_strobe_start) begin
          if (alt || interrupt_acknowledge_strobe_seen) begin                           // R17
            next_state     = ST_VECT;
            next_rdata     = out_cmd;                           // R16
            next_interrupt_acknowledge_strobe_seen = 1'b0;
          end else begin
            next_state     = ST_SKIP;                           // R18
            next_interrupt_acknowledge_strobe_seen = 1'b1;
          end
        end else if (rd_req) begin
          next_state    = ST_READ;
          next_dma_acc  = dma_acknowledge_input;
          next_acc_addr = eff_addr;
          if (dma_acknowledge_input) begin
            next_rdata = outbox[{1'b1, dma_rptr}];              // R07
          end else begin
            case (region(eff_addr))
              RGN_INBOX:  next_rdata = inbox[eff_addr[4:0]];
              RGN_OUTBOX: next_rdata = outbox[eff_addr[4:0]];   // R11
              RGN_CTRL: begin
                case (eff_addr[4:0])
                  OFS_IN_CMD:   next_rdata = in_cmd;
                  OFS_OUT_CMD:  next_rdata = out_cmd;
                  OFS_OUT_BUSY: next_rdata = {7'h00, out_busy};
                  OFS_IN_BUSY:  next_rdata = {7'h00, in_busy};
                  OFS_CONFIG:   next_rdata = cfg;
                  default:      next_rdata = UNMAPPED_READ;
                endcase
              end
              default: next_rdata = UNMAPPED_READ;
            endcase
          end
        end else if (wr_req) begin
          next_state    = ST_WRITE;
          next_dma_acc  = dma_acknowledge_input;
          next_acc_addr = eff_addr;
          next_wdata    = BUS.d;
        end
      end
      ST_READ: begin
        if (!rd_req) begin
          next_state = ST_IDLE;
          if (dma_acc) begin
            next_dma_rptr = dma_rptr + 4'h1;
          end
        end
      end
      ST_WRITE: begin
        if (wr_req) begin
          next_wdata = BUS.d;
        end else begin
          // commit at the end of the strobe, when data is surely settled
          next_state = ST_IDLE;
          if (dma_acc) begin
            in_we         = 1'b1;                               // R07
            in_widx       = {1'b1, dma_wptr};
            next_dma_wptr = dma_wptr + 4'h1;
          end else if (region(acc_addr) == RGN_INBOX) begin
            in_we   = 1'b1;                                     // R08 R11
            in_widx = acc_addr[4:0];
          end else if (region(acc_addr) == RGN_CTRL) begin
            case (acc_addr[4:0])
              OFS_IN_CMD: begin
                next_in_cmd   = wdata;
                next_in_busy  = 1'b1;
                next_dma_wptr = 4'h0;
              end
              OFS_OUT_BUSY: begin
                if (!wdata[0]) begin
                  next_out_busy = 1'b0;                         // R14
                end
              end
              OFS_CONFIG: next_cfg = wdata;                     // R09
              default: ;
            endcase
          end
        end
      end
      ST_VECT, ST_SKIP: begin
        if (BUS.interrupt_acknowledge_strobe_n) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (DSP_IN_DONE) begin
      next_in_busy = 1'b0;
    end
    // a processor command written in the same cycle keeps busy set
    if (state == ST_WRITE && !wr_req && !dma_acc && region(acc_addr) == RGN_CTRL
        && acc_addr[4:0] == OFS_IN_CMD) begin
      next_in_busy = 1'b1;
    end
    // the DSP's new command wins over a simultaneous clear
    if (DSP_CMD_WE) begin
      next_out_cmd  = DSP_CMD_DATA;                             // R13
      next_out_busy = 1'b1;
      next_dma_rptr = 4'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state       <= ST_IDLE;
      rdata       <= 8'h00;
      wdata       <= 8'h00;
      cfg         <= CFG_RESET;                                 // R10
      in_cmd      <= 8'h00;
      out_cmd     <= 8'h00;
      in_busy     <= 1'b0;
      out_busy    <= 1'b0;
      mux_mode    <= 1'b0;
      interrupt_acknowledge_strobe_seen   <= 1'b0;
      dma_acc     <= 1'b0;
      acc_addr    <= 7'h00;
      lat_addr    <= 7'h00;
      dma_rptr    <= 4'h0;
      dma_wptr    <= 4'h0;
      prev_interrupt_acknowledge_strobe_n <= 1'b1;
    end else begin
      state       <= next_state;
      rdata       <= next_rdata;
      wdata       <= next_wdata;
      cfg         <= next_cfg;
      in_cmd      <= next_in_cmd;
      out_cmd     <= next_out_cmd;
      in_busy     <= next_in_busy;
      out_busy    <= next_out_busy;
      mux_mode    <= next_mux_mode;
      interrupt_acknowledge_strobe_seen   <= next_interrupt_acknowledge_strobe_seen;
      dma_acc     <= next_dma_acc;
      acc_addr    <= next_acc_addr;
      lat_addr    <= next_lat_addr;
      dma_rptr    <= next_dma_rptr;
      dma_wptr    <= next_dma_wptr;
      prev_interrupt_acknowledge_strobe_n <= next_prev_interrupt_acknowledge_strobe_n;
    end
  end

  // =====================================================
  // mailbox storage; contents are not reset, software fills before use
  always_ff @(posedge CLK) begin
    if (in_we) begin
      inbox[in_widx] <= wdata;
    end
    if (DSP_OUT_WE) begin
      outbox[DSP_OUT_IDX] <= DSP_OUT_DATA;
    end
    DSP_IN_DATA <= inbox[DSP_IN_IDX];
  end

  // =====================================================
  // outputs
  always_comb begin
    BUS.dev_d    = rdata;
    BUS.dev_oe_n = !(state == ST_READ || state == ST_VECT);
    BUS.int_n    = !(out_busy && cfg[CFG_INTERRUPT_MASK_BIT_BIT]);          // R13 R15 R20
    DSP_IN_CMD   = in_cmd;
    IN_BUSY      = in_busy;
    OUT_BUSY     = out_busy;
    DMA_MODE     = dma;
    MUX_MODE     = mux_mode;
    ALT_STYLE    = alt;
  end
endmodule // hmp_device
`default_nettype wire

// ---- hmp_host.sv ----
// processor end: drives the strobes and pins of the mailbox port
`timescale 1ns/1ps
`default_nettype none
module hmp_host
  import hmp_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  hmp_bus_if.host         BUS,
  input  wire logic       CFG_ALT,
  input  wire logic       CFG_MUX,
  input  wire logic       CFG_DMA,
  input  wire logic       REQ,
  input  wire logic       REQ_WR,
  input  wire logic       REQ_DMA,
  input  wire logic       REQ_INTERRUPT_ACKNOWLEDGE_STROBE,
  input  wire logic [6:0] REQ_ADDR,
  input  wire logic [7:0] REQ_DATA,
  output logic            BUSY,
  output logic            DONE,
  output logic      [7:0] RDATA,
  output logic            IRQ
);
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_ALE  = 4'b0010,
    HS_STRB = 4'b0100,
    HS_GAP  = 4'b1000
  } hmp_hstate_t;

  hmp_hstate_t state, next_state;
  logic [3:0]  cnt, next_cnt;
  logic        wr, dma_acc, interrupt_acknowledge_strobe, next_wr, next_dma_acc, next_interrupt_acknowledge_strobe, next_done;
  logic [6:0]  addr, next_addr;
  logic [7:0]  data, next_data, next_rdata;
  logic        mux;

  always_comb begin
    // alternative style always uses separate buses
    mux          = CFG_MUX && !CFG_ALT;                         // R04
    next_state   = state;
    next_cnt     = cnt;
    next_wr      = wr;
    next_dma_acc = dma_acc;
    next_interrupt_acknowledge_strobe    = interrupt_acknowledge_strobe;
    next_addr    = addr;
    next_data    = data;
    next_rdata   = RDATA;
    next_done    = 1'b0;
    case (state)
      HS_IDLE: begin
        if (REQ) begin
          next_wr      = REQ_WR;
          next_dma_acc = REQ_DMA && CFG_DMA;                    // R07
          next_interrupt_acknowledge_strobe    = REQ_INTERRUPT_ACKNOWLEDGE_STROBE;
          next_addr    = REQ_ADDR;
          next_data    = REQ_DATA;
          next_cnt     = 4'h0;
          next_state   = (mux && !REQ_INTERRUPT_ACKNOWLEDGE_STROBE && !(REQ_DMA && CFG_DMA)) ? HS_ALE : HS_STRB;
        end
      end
      HS_ALE: begin
        next_cnt = cnt + 4'h1;
        if (cnt == ALE_CYC - 4'h1) begin
          next_cnt   = 4'h0;
          next_state = HS_STRB;
        end
      end
      HS_STRB: begin
        next_cnt = cnt + 4'h1;
        if (cnt == STROBE_CYC - 4'h1) begin
          next_cnt   = 4'h0;
          next_state = HS_GAP;
          next_done  = 1'b1;
          if (!wr) begin
            next_rdata = BUS.d;
          end
        end
      end
      HS_GAP: begin
        next_cnt = cnt + 4'h1;
        if (cnt == GAP_CYC - 4'h1) begin
          next_cnt   = 4'h0;
          next_state = HS_IDLE;
        end
      end
      default: next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state   <= HS_IDLE;
      cnt     <= 4'h0;
      wr      <= 1'b0;
      dma_acc <= 1'b0;
      interrupt_acknowledge_strobe    <= 1'b0;
      addr    <= 7'h00;
      data    <= 8'h00;
      RDATA   <= 8'h00;
      DONE    <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      wr      <= next_wr;
      dma_acc <= next_dma_acc;
      interrupt_acknowledge_strobe    <= next_interrupt_acknowledge_strobe;
      addr    <= next_addr;
      data    <= next_data;
      RDATA   <= next_rdata;
      DONE    <= next_done;
    end
  end

  // =====================================================
  // pin drive
  always_comb begin
    logic on;
    on         = (state == HS_STRB);
    BUSY       = (state != HS_IDLE);
    IRQ        = !BUS.int_n;
    BUS.mode   = CFG_ALT;                                       // R01
    BUS.ale    = mux ? (state == HS_ALE) : 1'b1;                // R02 R04
    BUS.cs_n   = !(on && !interrupt_acknowledge_strobe && !dma_acc);
    BUS.interrupt_acknowledge_strobe_n = !(on && interrupt_acknowledge_strobe);
    if (CFG_ALT) begin
      BUS.rd_n = !(on && !interrupt_acknowledge_strobe);
      BUS.wr_n = !wr;
    end else begin
      BUS.rd_n = !(on && !interrupt_acknowledge_strobe && !wr);
      BUS.wr_n = !(on && !interrupt_acknowledge_strobe && wr);
    end
    // address lines carry the low address bits; bit 4 goes by the shared pin
    BUS.addr    = {addr[6:5], 1'b0, addr[3:0]};                 // R03 R05
    BUS.shared_ack_addr4_pin = CFG_DMA ? !(on && dma_acc) : addr[4]; // R06 R12
    // in multiplexed use the address also rides the data lines under the address strobe
    BUS.host_d    = (state == HS_ALE) ? {1'b0, addr} : data;   // R19
    BUS.host_oe_n = !((state == HS_ALE) || (on && wr && !interrupt_acknowledge_strobe));
  end
endmodule // hmp_host
`default_nettype wire

// ---- hmp_bus_checker.sv ----
// assertions on the host bus between the processor end and the device end
`timescale 1ns/1ps
`default_nettype none
module hmp_bus_checker (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       mode,
  input wire logic       ale,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       interrupt_acknowledge_strobe_n,
  input wire logic       int_n,
  input wire logic [6:0] addr,
  input wire logic       shared_ack_addr4_pin,
  input wire logic [7:0] host_d,
  input wire logic       host_oe_n,
  input wire logic [7:0] dev_d,
  input wire logic       dev_oe_n
);
  logic rd_act, wr_act, cfg_seen, next_cfg_seen, interrupt_acknowledge_strobe_odd, next_interrupt_acknowledge_strobe_odd, interrupt_acknowledge_strobe_prev;
  assign rd_act = !cs_n && !rd_n && (!mode || wr_n);
  assign wr_act = !cs_n && (mode ? (!rd_n && !wr_n) : !wr_n);
  // =====================================================
  // helper state
  // config write seen is over-approximated, which only weakens the mask check
  always_comb begin
    next_cfg_seen = cfg_seen || (wr_act && addr == 7'h44);
    next_interrupt_acknowledge_strobe_odd = interrupt_acknowledge_strobe_odd;
    if (!mode && !interrupt_acknowledge_strobe_n && interrupt_acknowledge_strobe_prev) begin
      next_interrupt_acknowledge_strobe_odd = !interrupt_acknowledge_strobe_odd;
    end
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg_seen  <= 1'b0;
      interrupt_acknowledge_strobe_odd  <= 1'b0;
      interrupt_acknowledge_strobe_prev <= 1'b1;
    end else begin
      cfg_seen  <= next_cfg_seen;
      interrupt_acknowledge_strobe_odd  <= next_interrupt_acknowledge_strobe_odd;
      interrupt_acknowledge_strobe_prev <= interrupt_acknowledge_strobe_n;
    end
  end
  // =====================================================
  // properties
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence rd_take;
    $fell(rd_n) && rd_act;
  endsequence
  sequence interrupt_acknowledge_strobe_take;
    !interrupt_acknowledge_strobe_n && interrupt_acknowledge_strobe_prev;
  endsequence
  sequence clr_busy;
    wr_act && !host_oe_n && addr == 7'h42 && !shared_ack_addr4_pin && host_d == 8'h00
    ##1 !wr_act;
  endsequence
  a_read_answer: assert property (rd_take |-> ##[1:2] !dev_oe_n)
    else $error("read strobe not answered");
  a_unmapped_ff: assert property (rd_take ##0 addr[6:5] == 2'h3 |-> ##3 dev_d == 8'hff)
    else $error("unmapped read not ff");
  a_dev_release: assert property ((rd_n && interrupt_acknowledge_strobe_n) [*4] |-> dev_oe_n)
    else $error("device drives bus without strobe");
  a_first_interrupt_acknowledge_strobe: assert property (interrupt_acknowledge_strobe_take ##0 (!mode && !interrupt_acknowledge_strobe_odd) |-> ##1 dev_oe_n [*3])
    else $error("vector driven on first acknowledge");
  a_vector_drive: assert property (interrupt_acknowledge_strobe_take ##0 (mode || interrupt_acknowledge_strobe_odd) |-> ##[1:2] !dev_oe_n)
    else $error("vector not driven");
  a_busy_clear: assert property (clr_busy |-> ##[0:2] int_n)
    else $error("interrupt held after busy clear");
  a_irq_masked: assert property (!cfg_seen |-> int_n)
    else $error("interrupt raised while masked");
  a_alt_separate: assert property (mode |-> ale)
    else $error("address strobe used in alternative style");
  a_reset_idle: assert property ($fell(SYS_RST) |-> int_n && dev_oe_n)
    else $error("bus not idle after reset");
endmodule // hmp_bus_checker
`default_nettype wire

// ---- test_host_bus_mailbox_port.sv ----
// self-checking bench: host end and device end joined over the bus interface
`timescale 1ns/1ps
`default_nettype none
module test_host_bus_mailbox_port
  import hmp_pkg::*;
;
  logic       clk, sys_rst, alt, mux, dma_cfg, req, req_wr, req_dma, req_interrupt_acknowledge_strobe;
  logic       busy, done, irq, out_we, cmd_we, in_done, in_busy, out_busy;
  logic       dma_mode, mux_mode, alt_style;
  logic [6:0] req_addr;
  logic [4:0] out_idx, in_idx;
  logic [7:0] req_data, rdata, dsp_in_data, dsp_in_cmd, out_data, cmd_data, v;
  logic [7:0] obox[32], ibox[32];
  logic [8:0] q[$], note;
  int         errors, check_count, seed;
  hmp_bus_if i_hmp_bus_if ();
  hmp_device i_hmp_device (.CLK(clk), .SYS_RST(sys_rst), .BUS(i_hmp_bus_if.dev),
    .DSP_OUT_WE(out_we), .DSP_OUT_IDX(out_idx), .DSP_OUT_DATA(out_data), .DSP_CMD_WE(cmd_we),
    .DSP_CMD_DATA(cmd_data), .DSP_IN_IDX(in_idx), .DSP_IN_DATA(dsp_in_data),
    .DSP_IN_CMD(dsp_in_cmd), .IN_BUSY(in_busy), .DSP_IN_DONE(in_done), .OUT_BUSY(out_busy),
    .DMA_MODE(dma_mode), .MUX_MODE(mux_mode), .ALT_STYLE(alt_style));
  hmp_host i_hmp_host (.CLK(clk), .SYS_RST(sys_rst), .BUS(i_hmp_bus_if.host), .CFG_ALT(alt),
    .CFG_MUX(mux), .CFG_DMA(dma_cfg), .REQ(req), .REQ_WR(req_wr), .REQ_DMA(req_dma),
    .REQ_INTERRUPT_ACKNOWLEDGE_STROBE(req_interrupt_acknowledge_strobe), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .BUSY(busy), .DONE(done),
    .RDATA(rdata), .IRQ(irq));
  hmp_bus_checker i_hmp_bus_checker (.CLK(clk), .SYS_RST(sys_rst), .mode(i_hmp_bus_if.mode),
    .ale(i_hmp_bus_if.ale), .cs_n(i_hmp_bus_if.cs_n), .rd_n(i_hmp_bus_if.rd_n),
    .wr_n(i_hmp_bus_if.wr_n), .interrupt_acknowledge_strobe_n(i_hmp_bus_if.interrupt_acknowledge_strobe_n), .int_n(i_hmp_bus_if.int_n),
    .addr(i_hmp_bus_if.addr), .shared_ack_addr4_pin(i_hmp_bus_if.shared_ack_addr4_pin),
    .host_d(i_hmp_bus_if.host_d), .host_oe_n(i_hmp_bus_if.host_oe_n),
    .dev_d(i_hmp_bus_if.dev_d), .dev_oe_n(i_hmp_bus_if.dev_oe_n));
  // =====================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst(input logic a, input logic m);
    sys_rst = 1'b1;
    alt = a;
    mux = m;
    step(6);
    sys_rst = 1'b0;
    // the address strobe level is caught into mux_mode only at the first edge after release; the strap pin is seen at once
    step(1);
  endtask
  // the expected read value is queued before the request; the monitor pops it on done
  task automatic acc(input logic w, k, i_ack, input logic [6:0] a, input logic [7:0] x,
                     input logic [8:0] e);
    int i;
    for (i = 0; i < 20 && busy !== 1'b0; i++) step(1);
    q.push_back(e);
    {req, req_wr, req_dma, req_interrupt_acknowledge_strobe, req_addr, req_data} = {1'b1, w, k, i_ack, a, x};
    step(1);
    req = 1'b0;
    for (i = 0; i < 40 && done !== 1'b1; i++) step(1);
    check(8'(done), 8'h01);
    // writes commit a little after the strobe ends
    step(3);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    acc(1'b0, 1'b0, 1'b0, a, 8'h00, {1'b1, e});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] x);
    acc(1'b1, 1'b0, 1'b0, a, x, 9'h000);
  endtask
  task automatic dsp_out(input logic [4:0] i, input logic [7:0] x);
    {out_we, out_idx, out_data} = {1'b1, i, x};
    step(1);
    out_we = 1'b0;
  endtask
  task automatic dsp_cmd(input logic [7:0] x);
    {cmd_we, cmd_data} = {1'b1, x};
    step(1);
    cmd_we = 1'b0;
  endtask
  task automatic in_check(input logic [4:0] i, input logic [7:0] e);
    in_idx = i;
    step(2);
    check(dsp_in_data, e);
  endtask
  always @(posedge clk) begin
    if (done === 1'b1) begin
      note = q.pop_front();
      if (note[8]) check(rdata, note[7:0]);
    end
  end
  initial begin
    #200000;
    errors++;
    end_sim;
  end
  // =====================================================
  // main sequence
  initial begin
    {seed, errors, check_count} = {32'd71, 32'd0, 32'd0};
    {sys_rst, alt, mux, dma_cfg, req, req_wr, req_dma, req_interrupt_acknowledge_strobe} = 8'h80;
    {out_we, cmd_we, in_done, req_addr, req_data, out_idx, in_idx, out_data, cmd_data} = '0;
    rst(1'b0, 1'b0);
    rd(7'h44, CFG_RESET);
    rd(7'h43, 8'h00);
    check(8'(dma_mode), 8'h00);
    rd(7'h60, UNMAPPED_READ);
    rd(7'h45, UNMAPPED_READ);
    for (int i = 0; i < MBX_BYTES; i++) begin
      ibox[i] = 8'($random(seed));
      obox[i] = 8'($random(seed));
      wr(7'(i), ibox[i]);
      dsp_out(5'(i), obox[i]);
    end
    for (int i = 0; i < MBX_BYTES; i++) begin
      in_check(5'(i), ibox[i]);
      rd(7'h20 + 7'(i), obox[i]);
    end
    wr(7'h20, ~obox[0]);
    rd(7'h20, obox[0]);
    v = 8'($random(seed));
    wr(7'h40, v);
    check(8'(in_busy), 8'h01);
    check(dsp_in_cmd, v);
    in_done = 1'b1;
    step(1);
    in_done = 1'b0;
    step(1);
    check(8'(in_busy), 8'h00);
    v = 8'($random(seed));
    dsp_cmd(v);
    check(8'(out_busy), 8'h01);
    check(8'(irq), 8'h00);
    rd(7'h41, v);
    rd(7'h42, 8'h01);
    wr(7'h44, 8'h02);
    check(8'(irq), 8'h01);
    acc(1'b0, 1'b0, 1'b1, 7'h00, 8'h00, {1'b1, UNMAPPED_READ});
    acc(1'b0, 1'b0, 1'b1, 7'h00, 8'h00, {1'b1, v});
    wr(7'h44, 8'h00);
    check(8'(irq), 8'h00);
    wr(7'h44, 8'h02);
    wr(7'h42, 8'h00);
    check(8'(irq), 8'h00);
    check(8'(out_busy), 8'h00);
    wr(7'h44, 8'h03);
    dma_cfg = 1'b1;
    check(8'(dma_mode), 8'h01);
    dsp_cmd(v);
    for (int i = 0; i < HALF_BYTES; i++) acc(1'b0, 1'b1, 1'b0, 7'h00, 8'h00,
                                             {1'b1, obox[HALF_BYTES + i]});
    rd(7'h30, obox[0]);
    wr(7'h40, v);
    for (int i = 0; i < 4; i++) begin
      ibox[16 + i] = 8'($random(seed));
      acc(1'b1, 1'b1, 1'b0, 7'h00, ibox[16 + i], 9'h000);
    end
    for (int i = 0; i < 4; i++) in_check(5'(16 + i), ibox[16 + i]);
    wr(7'h10, 8'h5a);
    in_check(5'h00, 8'h5a);
    dma_cfg = 1'b0;
    rst(1'b1, 1'b0);
    check(8'(alt_style), 8'h01);
    check(8'(mux_mode), 8'h00);
    rd(7'h44, CFG_RESET);
    v = 8'($random(seed));
    dsp_cmd(v);
    acc(1'b0, 1'b0, 1'b1, 7'h00, 8'h00, {1'b1, v});
    rst(1'b0, 1'b1);
    check(8'(mux_mode), 8'h01);
    check(8'(alt_style), 8'h00);
    dsp_out(5'h1f, v);
    rd(7'h3f, v);
    end_sim;
  end
endmodule // test_host_bus_mailbox_port
`default_nettype wire
